/* mem_system_model.sv */
// memory system stand-in that stalls at random
`timescale 1ns/1ps
module mem_system_model
(
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    input  wire logic   mem_valid,
    output logic        mem_ready,
    output logic [15:0] acc_count
);
    logic [7:0] stall_reg;
    // stall pattern and access count; any order, no size needed
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
        begin
            stall_reg <= 8'hA5;
            acc_count <= 16'h0000;
        end
        else
        begin
            stall_reg <= {stall_reg[6:0], ^(stall_reg & 8'hB8)};
            acc_count <= acc_count + 16'(mem_valid && mem_ready);
        end
    assign mem_ready = stall_reg[0] | stall_reg[1]; // stalls about a quarter
endmodule : mem_system_model

/* vec_mem_cfg.svh */
// timing-free constants for the vector element access filter
`ifndef VEC_MEM_CFG_SVH
`define VEC_MEM_CFG_SVH
`define VM_OVERREAD_NORMAL_BYTES 64
`define VM_OVERREAD_GATHER_BYTES 128
`define VM_MEMTYPE_NORMAL 2'h0
`define VM_MEMTYPE_DEVICE 2'h1
`define VM_MEMTYPE_DEVICE_G 2'h2
`endif

/* vec_mem_pkg.sv */
// types shared by the vector element access filter
package vec_mem_pkg;
    typedef enum logic [2:0]
    {
        op_load_plain_type    = 3'h0,
        op_load_first_fault   = 3'h1,
        op_load_no_fault      = 3'h3,
        op_load_streaming     = 3'h2,
        op_prefetch           = 3'h6,
        op_store              = 3'h7
    } op_kind_type;
    typedef enum logic [1:0]
    {
        acc_contig_unpred = 2'h0,
        acc_contig_pred   = 2'h1,
        acc_gather        = 2'h3
    } acc_shape_type;
    typedef enum logic [1:0]
    {
        st_idle   = 2'h0,
        st_run    = 2'h1,
        st_done   = 2'h3
    } state_type;
endpackage : vec_mem_pkg

/* vec_mem_rules_chk.sv */
// assertion checker for the vector element access filter
`timescale 1ns/1ps
`include "vec_mem_cfg.svh"
module vec_mem_rules_chk
    import vec_mem_pkg::*;
#(
    parameter int addr_width = 48,
    parameter int elem_count = 16
)
(
    input wire logic                  clk_sys,
    input wire logic                  rst_n,
    input wire logic                  start,
    input wire op_kind_type           op_kind,
    input wire logic                  elem_valid,
    input wire logic                  elem_ready,
    input wire logic [1:0]            elem_memtype,
    input wire logic                  mem_valid,
    input wire logic [addr_width-1:0] mem_addr,
    input wire logic [addr_width-1:0] mem_window_base,
    input wire logic                  mem_window_128,
    input wire logic                  mem_is_write,
    input wire logic [elem_count-1:0] fault_progress_predicate,
    input wire logic                  busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    op_kind_type op_kind_reg;
    // op of the instruction in flight
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            op_kind_reg <= op_load_plain_type;
        else if (start && !busy)
            op_kind_reg <= op_kind;
    // accepted start, and a device element taken for a given op
    sequence s_start;
        start && !busy;
    endsequence
    sequence s_dev_take(op_kind_type k);
        elem_valid && elem_ready && elem_memtype != `VM_MEMTYPE_NORMAL && op_kind_reg == k;
    endsequence
    a_pref_no_dev: assert property (s_dev_take(op_prefetch) |=> !mem_valid)
        else $error("prefetch reached device memory");
    a_nofault_no_dev: assert property (s_dev_take(op_load_no_fault) |=> !mem_valid)
        else $error("no-fault load reached device memory");
    a_window_64: assert property (mem_valid && !mem_window_128 |->
        mem_window_base[5:0] == 6'h00 && mem_addr - mem_window_base < 64)
        else $error("access outside its 64-byte window");
    a_window_128: assert property (mem_valid && mem_window_128 |->
        mem_window_base[6:0] == 7'h00 && mem_addr - mem_window_base < 128
        && op_kind_reg == op_load_streaming)
        else $error("bad 128-byte window");
    a_write_store: assert property (mem_valid |-> mem_is_write == (op_kind_reg == op_store))
        else $error("write flag does not match op");
    a_pred_init: assert property (s_start |=> &fault_progress_predicate)
        else $error("predicate not all ones after start");
    a_pred_only_fall: assert property (busy |=>
        (fault_progress_predicate & ~$past(fault_progress_predicate)) == '0)
        else $error("predicate bit set during run");
    a_issue_on_take: assert property ($rose(mem_valid) |-> $past(elem_valid && elem_ready))
        else $error("access issued without a taken element");
endmodule : vec_mem_rules_chk
bind vector_memory_access_rules vec_mem_rules_chk #(.addr_width(addr_width),
    .elem_count(elem_count)) chk (.clk_sys, .rst_n, .start, .op_kind, .elem_valid,
    .elem_ready, .elem_memtype, .mem_valid, .mem_addr, .mem_window_base, .mem_window_128,
    .mem_is_write, .fault_progress_predicate, .busy);

/* vector_memory_access_rules.sv */
// element access filter between vector load/store logic and the memory system
// Function
// - address dependencies between vector load reads impose no read ordering.
// - same-location read pairs involving a vector load skip internal visibility.
// - repeated same-location writes of one store issue by ascending element number.
// - other element effects of one store may issue in any order.
// - element order free; memory system never told the element size.
// - prefetch elements to Device memory issue nothing.
// - no-fault loads suppress every Device element, recording it in the predicate.
// - first-fault loads touch Device only for the first active element.
// - no speculative Device accesses except bounded vector load over-reads.
// - Device over-read stays in a 64-byte aligned block with a requested byte.
// - streaming gathering loads may over-read within an aligned 128-byte block.
// - unpredicated contiguous access crossing an attribute boundary is flagged.
// - predicated contiguous flagged only with active elements on both sides.
// - gather/scatter flagged only when an active element access straddles.
// - inactive elements never cause the boundary flag.
`timescale 1ns/1ps
`include "vec_mem_cfg.svh"
module vector_memory_access_rules
    import vec_mem_pkg::*;
#(
    parameter int addr_width = 48,
    parameter int elem_count = 16
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  start,
    input  wire op_kind_type           op_kind,
    input  wire acc_shape_type         acc_shape,
    input  wire logic [elem_count-1:0] active_mask,
    input  wire logic                  elem_valid,
    input  wire logic [addr_width-1:0] elem_addr,
    input  wire logic [3:0]            elem_bytes,
    input  wire logic [1:0]            elem_memtype,
    input  wire logic [7:0]            elem_attr_tag,
    input  wire logic                  elem_attr_split,
    input  wire logic                  elem_fault,
    output logic                       elem_ready,
    input  wire logic                  mem_ready,
    output logic                       mem_valid,
    output logic [addr_width-1:0]      mem_addr,
    output logic [addr_width-1:0]      mem_window_base,
    output logic                       mem_window_128,
    output logic                       mem_is_write,
    output logic [elem_count-1:0]      fault_progress_predicate,
    output logic                       boundary_unpredictable,
    output logic                       busy,
    output logic                       done
);
    // ----------------------------------------------------------------
    // parameter limits
    // ----------------------------------------------------------------
    // index counter and predicate loop serve 2 to 256 elements
    if (elem_count < 2 || elem_count > 256)
    begin : g_bad_count
        $error("elem_count out of range");
    end
    // the 128-byte window mask needs at least 8 address bits
    if (addr_width < 8)
    begin : g_bad_width
        $error("addr_width too small");
    end


    // ----------------------------------------------------------------
    // element sequencing
    // ----------------------------------------------------------------
    localparam int idx_w = $clog2(elem_count);
    // instruction held for the whole walk
    state_type             state_reg;
    logic [idx_w-1:0]      idx_reg;
    op_kind_type           op_reg;
    acc_shape_type         shape_reg;
    logic [elem_count-1:0] mask_reg;
    logic                  first_seen_reg;
    logic                  have_tag_reg;
    logic [7:0]            tag_reg;

    // per-element decisions
    logic                  cur_active;
    logic                  is_device;
    logic                  suppress;
    logic                  take;
    logic                  last_elem;
    logic                  hold_out;

    // clears the low address bits to the window's natural alignment
    function automatic logic [addr_width-1:0] align_down(
        input logic [addr_width-1:0] a,
        input int                    bytes
    );
        logic [addr_width-1:0] m;
        m = ~(addr_width'(bytes) - addr_width'(1));
        return a & m;
    endfunction : align_down

    // ops that record suppressed or faulted elements in the predicate
    function automatic logic fault_tracked(input op_kind_type k);
        return (k == op_load_no_fault) || (k == op_load_first_fault);
    endfunction : fault_tracked

    // attribute boundary seen by a contiguous access at this element
    function automatic logic attr_boundary(
        input logic       split,
        input logic       have_prev,
        input logic [7:0] prev_tag,
        input logic [7:0] cur_tag
    );
        return split || (have_prev && prev_tag != cur_tag);
    endfunction : attr_boundary

    // current element and end of walk
    assign cur_active = mask_reg[idx_reg];
    assign last_elem  = (idx_reg == idx_w'(elem_count - 1));

    // device type from translated attributes, decided before issue
    assign is_device  = (elem_memtype != `VM_MEMTYPE_NORMAL);

    // suppression decision per element
    always_comb
    begin
        suppress = 1'b0;
        if (!cur_active)
            suppress = 1'b1;
        else if (is_device)
        begin
            unique case (op_reg)
                op_prefetch:         suppress = 1'b1;
                op_load_no_fault:    suppress = 1'b1;
                op_load_first_fault: suppress = first_seen_reg;
                default:             suppress = 1'b0;
            endcase
        end
        else if (op_reg == op_prefetch)
            suppress = 1'b0;
        // a faulted element after the first is never issued by a no-fault or first-fault load
        if (cur_active && elem_fault && first_seen_reg && fault_tracked(op_reg))
            suppress = 1'b1;
    end

    // output stage holds a word until the memory side takes it
    assign hold_out   = mem_valid && !mem_ready;
    assign elem_ready = (state_reg == st_run) && !hold_out;
    assign take       = elem_ready && elem_valid;
    assign busy       = (state_reg == st_run);

    // a new start is taken in the done cycle even while the last request
    // still waits on the memory side; its fields stay in the output stage
    // sequencer: elements walk in ascending order, which also serves stores
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= st_idle;
            idx_reg   <= '0;
            op_reg    <= op_load_plain_type;
            shape_reg <= acc_contig_unpred;
            mask_reg  <= '0;
        end
        else
        begin
            unique case (state_reg)
                st_idle, st_done:
                    if (start)
                    begin
                        state_reg <= st_run;
                        idx_reg   <= '0;
                        op_reg    <= op_kind;
                        shape_reg <= acc_shape;
                        mask_reg  <= (acc_shape == acc_contig_unpred) ? '1 : active_mask;
                    end
                    else
                        state_reg <= st_idle;
                // one element per take, inactive ones included
                st_run:
                    if (take)
                    begin
                        idx_reg <= idx_reg + idx_w'(1);
                        if (last_elem)
                            state_reg <= st_done;
                    end
                default:
                    state_reg <= st_idle;
            endcase
        end
    end

    // done stands for one cycle, whether or not a new start follows
    assign done = (state_reg == st_done);

    // ----------------------------------------------------------------
    // first-fault tracking and progress predicate
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            first_seen_reg           <= 1'b0;
            fault_progress_predicate <= '0;
        end
        else if (start && state_reg != st_run)
        begin
            first_seen_reg           <= 1'b0;
            fault_progress_predicate <= '1;
        end
        else if (take && cur_active)
        begin
            first_seen_reg <= 1'b1;
            // a fault on the first element is reported by the core, not here;
            // suppressed device or faulted elements clear it from here upward
            if (fault_tracked(op_reg) && suppress)
            begin
                for (int i = 0; i < elem_count; i++)
                    if (idx_w'(i) >= idx_reg)
                        fault_progress_predicate[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // boundary crossing detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            have_tag_reg           <= 1'b0;
            tag_reg                <= 8'h00;
            boundary_unpredictable <= 1'b0;
        end
        else if (start && state_reg != st_run)
        begin
            have_tag_reg           <= 1'b0;
            boundary_unpredictable <= 1'b0;
        end
        else if (take && cur_active)
        begin
            // only active elements record their attribute
            have_tag_reg <= 1'b1;
            tag_reg      <= elem_attr_tag;
            unique case (shape_reg)
                acc_gather:
                    if (elem_attr_split)
                        boundary_unpredictable <= 1'b1;
                acc_contig_pred:
                    if (attr_boundary(elem_attr_split, have_tag_reg, tag_reg, elem_attr_tag))
                        boundary_unpredictable <= 1'b1;
                default:
                    if (attr_boundary(elem_attr_split, have_tag_reg, tag_reg, elem_attr_tag))
                        boundary_unpredictable <= 1'b1;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // memory request stage; no element size is passed on
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_valid       <= 1'b0;
            mem_addr        <= '0;
            mem_window_base <= '0;
            mem_window_128  <= 1'b0;
            mem_is_write    <= 1'b0;
        end
        else if (!hold_out)
        begin
            // a stalled request keeps every field until it is taken
            mem_valid <= take && !suppress;
            if (take && !suppress)
            begin
                mem_addr     <= elem_addr;
                mem_is_write <= (op_reg == op_store);
                // over-read window limits for device reads
                if (op_reg == op_load_streaming && elem_memtype == `VM_MEMTYPE_DEVICE_G)
                begin
                    mem_window_base <= align_down(elem_addr, `VM_OVERREAD_GATHER_BYTES);
                    mem_window_128  <= 1'b1;
                end
                else
                begin
                    mem_window_base <= align_down(elem_addr, `VM_OVERREAD_NORMAL_BYTES);
                    mem_window_128  <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // ordering and element size
    // ----------------------------------------------------------------
    // reads leave one at a time and carry no dependency tracking, so a
    // later read never waits on an earlier one's address or data
    // stores walk elements upward, so repeated writes to one location
    // reach the memory side in ascending element order
    // the element size stays here: the memory side never sees it
    logic unused_bytes;
    assign unused_bytes = |elem_bytes;
endmodule : vector_memory_access_rules

/* vector_memory_access_rules_tb.sv */
// randomised testbench for the vector element access filter
`timescale 1ns/1ps
module vector_memory_access_rules_tb;
    import vec_mem_pkg::*;
    localparam int N = 8;
    typedef struct packed {logic [N-1:0] pred; logic [15:0] cnt; logic bnd;} expect_type;
    localparam op_kind_type OPS[6] = '{op_load_plain_type, op_load_first_fault,
        op_load_no_fault, op_load_streaming, op_prefetch, op_store};
    localparam acc_shape_type SHP[3] = '{acc_contig_unpred, acc_contig_pred, acc_gather};
    logic          clk_sys = 1'b0, rst_n = 1'b0, start = 1'b0, elem_valid = 1'b0;
    logic          elem_attr_split = 1'b0, elem_fault = 1'b0, elem_ready, mem_ready, mem_valid;
    logic          mem_window_128, mem_is_write, boundary_unpredictable, busy, done;
    op_kind_type   op_kind = op_load_plain_type;
    acc_shape_type acc_shape = acc_contig_unpred;
    logic [N-1:0]  active_mask = '0, fault_progress_predicate, sp, ft;
    logic [47:0]   elem_addr = '0, mem_addr, mem_window_base;
    logic [3:0]    elem_bytes = 4'h0;
    logic [1:0]    elem_memtype = 2'h0, mt[N];
    logic [7:0]    elem_attr_tag = 8'h00;
    logic [15:0]   acc_count;
    logic [31:0]   seed = 32'h0000_0049;
    int            failures = 0, checks_done = 0, cycles = 0;
    vector_memory_access_rules #(.elem_count(N)) dut (.clk_sys, .rst_n, .start, .op_kind,
        .acc_shape, .active_mask, .elem_valid, .elem_addr, .elem_bytes, .elem_memtype,
        .elem_attr_tag, .elem_attr_split, .elem_fault, .elem_ready, .mem_ready,
        .mem_valid, .mem_addr, .mem_window_base, .mem_window_128, .mem_is_write,
        .fault_progress_predicate, .boundary_unpredictable, .busy, .done);
    mem_system_model mem (.clk_sys, .rst_n, .mem_valid, .mem_ready, .acc_count);
    // clock and cycle limit
    initial forever #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            complete_run();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // predicate, access count and boundary flag expected for one instruction
    function automatic expect_type expect_of(op_kind_type op, acc_shape_type sh,
        logic [N-1:0] m);
        expect_type e;
        logic       seen;
        logic [1:0] lt;
        logic       sup;
        e = '{'1, 16'h0000, 1'b0};
        seen = 1'b0;
        lt = 2'h0;
        for (int i = 0; i < N; i++)
            if (m[i] || sh == acc_contig_unpred)
            begin
                e.bnd |= (sh == acc_gather) ? sp[i] : seen && mt[i] != lt;
                sup = mt[i] != 2'h0 && (op == op_prefetch || op == op_load_no_fault
                    || op == op_load_first_fault && seen);
                // faulted elements after the first are suppressed as well
                if (op == op_load_no_fault || op == op_load_first_fault)
                begin
                    sup |= ft[i] && seen;
                    if (sup)
                        e.pred &= ~({N{1'b1}} << i);
                end
                if (!sup)
                    e.cnt++;
                seen = 1'b1;
                lt = mt[i];
            end
        return e;
    endfunction : expect_of
    task automatic check_val(logic [15:0] got, logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    // one instruction: start, all elements in order, drain, compare
    task automatic run_one(int t);
        op_kind_type   op;
        acc_shape_type sh;
        expect_type    e;
        logic [15:0]   c0;
        op = OPS[t % 6];
        sh = SHP[(t / 6) % 3];
        for (int i = 0; i < N; i++)
        begin
            mt[i] = (t % 5 == 0) ? 2'h1 : (t % 7 == 0) ? 2'h0 : 2'(rnd() % 3);
            sp[i] = sh == acc_gather && rnd() % 3 == 0;
            ft[i] = rnd() % 4 == 0;
        end
        active_mask = (t % 8 == 1) ? '0 : N'(rnd());
        e = expect_of(op, sh, active_mask);
        op_kind = op;
        acc_shape = sh;
        start = 1'b1;
        c0 = acc_count;
        @(negedge clk_sys);
        start = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            elem_valid = 1'b1;
            elem_addr = {16'(rnd()), rnd()};
            elem_bytes = 4'(rnd());
            elem_memtype = mt[i];
            elem_attr_tag = 8'(mt[i]); // attribute id follows memory type
            elem_attr_split = sp[i];
            elem_fault = ft[i];
            #1;
            while (elem_ready !== 1'b1)
            begin
                @(negedge clk_sys);
                #1;
            end
            @(negedge clk_sys);
        end
        elem_valid = 1'b0;
        check_val(16'(done), 16'h0001);
        while (busy !== 1'b0 || mem_valid !== 1'b0)
            @(negedge clk_sys);
        check_val(16'(fault_progress_predicate), 16'(e.pred));
        check_val(acc_count - c0, e.cnt);
        check_val(16'(boundary_unpredictable), 16'(e.bnd));
        $display("test %0d ended", t);
    endtask : run_one
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // reset, then every op in every shape twice
    initial
    begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int t = 0; t < 36; t++)
            run_one(t);
        complete_run();
    end
endmodule : vector_memory_access_rules_tb
